// ===== ps_pkg.sv
package ps_pkg;
  // link widths and transaction decode
  localparam int DATA_W = 8;
  localparam int CA_BYTES = 6;
  localparam int LAT_CYC = 6;
  localparam logic [7:0] CMD_READ_BIT = 8'h80;
  localparam logic [7:0] CMD_REG_BIT = 8'h40;
  localparam int CLK_MHZ = 200;
  // timing figures, in ns, and derived cycle counts
  localparam int ACCESS_TIME_NS = 35;
  localparam int STOP_EXTRA_NS = 30;
  localparam int CLK_STOP_CYC = ((ACCESS_TIME_NS + STOP_EXTRA_NS) * CLK_MHZ
                                 + 999) / 1000;
  localparam int SLEEP_ENTRY_NS = 3000;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS * CLK_MHZ) / 1000;
  localparam int SLEEP_EXIT_NS = 100000;
  localparam int SLEEP_EXIT_CYC = (SLEEP_EXIT_NS * CLK_MHZ + 999) / 1000;
  localparam int PD_ENTRY_NS = 3000;
  localparam int PD_ENTRY_CYC = (PD_ENTRY_NS * CLK_MHZ) / 1000;
  localparam int PD_EXIT_NS = 150000;
  localparam int PD_EXIT_CYC = (PD_EXIT_NS * CLK_MHZ + 999) / 1000;
  localparam int POWER_ON_NS = 150000;
  localparam int POWER_ON_CYC = (POWER_ON_NS * CLK_MHZ + 999) / 1000;
  // register-space write targets carried in the last command-address byte
  localparam logic [7:0] REG_SEL_CR0 = 8'h00;
  localparam logic [7:0] REG_SEL_CR1 = 8'h01;
  localparam int PD_CTRL_POS = 7;
  localparam int SLEEP_POS = 5;
  localparam logic [7:0] CR0_RESET = 8'h80;
  localparam logic [7:0] CR1_RESET = 8'h00;
  // host commands
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_REG_WRITE} op_e;
endpackage : ps_pkg

// ===== ps_link.sv
`timescale 1ns/100ps
interface ps_link;
  logic sel_n; // select, low active, host driven
  logic ck; // true clock, host driven
  logic clock_complement; // complementary clock, host driven
  logic reset_n; // hardware reset, host driven
  logic [7:0] dq_h; // host data out
  logic dq_h_oe; // host drives data_lines
  logic [7:0] dq_d; // device data out
  logic dq_d_oe; // device drives data_lines
  logic rws_h; // host strobe out
  logic rws_h_oe; // host drives read_write_strobe
  logic rws_d; // device strobe out
  logic rws_d_oe; // device drives read_write_strobe
  modport dev (input sel_n, ck, clock_complement, reset_n, dq_h, dq_h_oe,
    rws_h, rws_h_oe, output dq_d, dq_d_oe, rws_d, rws_d_oe);
  modport host (output sel_n, ck, clock_complement, reset_n, dq_h, dq_h_oe,
    rws_h, rws_h_oe, input dq_d, dq_d_oe, rws_d, rws_d_oe);
endinterface : ps_link

// ===== ps_wait.sv
`timescale 1ns/100ps
// one-shot down counter, done pulses once when count expires
module ps_wait #(
  parameter int W = 16
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, low
  input wire logic start, // load count
  input wire logic [W-1:0] count, // cycles to wait
  output logic busy, // counting
  output logic done // one-cycle pulse at expiry
);
  logic [W-1:0] cnt_reg;
  // load on start, decrement while busy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= busy && (cnt_reg == W'(1));
      if (start) begin
        cnt_reg <= count;
        busy <= 1'b1;
      end else if (busy) begin
        cnt_reg <= cnt_reg - W'(1);
        busy <= (cnt_reg != W'(1));
      end
    end
  end
endmodule : ps_wait

// ===== ps_device.sv
`timescale 1ns/100ps
// Notes on behaviour
// - select high: standby, pins released
// - read latency: data released, strobe low
// - write latency: nobody drives data or strobe
// - device drives strobe during command-address phase
// - zero-latency write: strobe low or released
// - host never drives strobe in zero-latency write
// - zero-latency write ignores mask, writes all
// - stalled clock enters clock-stop after limit
// - clock-stop read keeps driving latched data
// - clock toggling again resumes the transfer
// - host raises select before max select time
// - host parks clock low, complement high
// - hybrid sleep bit set enters sleep
// - sleep keeps array and registers
// - select fall or reset wakes, clears bit
// - sleep exit reaches standby in exit time
// - power-down bit cleared enters deep power-down
// - array contents invalid after power-down
// - select low-high or reset ends power-down
// - power-down exit restores post-power-on state
// - refresh busy: strobe high demands extra latency
// - power-down watches only select and reset
module ps_device
  import ps_pkg::*;
#(
  parameter int STOP_CYC = CLK_STOP_CYC, // clock-stop detect cycles
  parameter int SLEEP_IN_CYC = SLEEP_ENTRY_CYC, // sleep entry delay
  parameter int SLEEP_OUT_CYC = SLEEP_EXIT_CYC, // sleep exit delay
  parameter int PD_IN_CYC = PD_ENTRY_CYC, // power-down entry delay
  parameter int PD_OUT_CYC = PD_EXIT_CYC // power-down exit delay
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, low; acts as power-on
  ps_link.dev bus, // link to host
  input wire logic refresh_busy, // internal refresh still running
  input wire logic [7:0] rd_data, // array read data
  output logic [7:0] wr_data, // array write data
  output logic wr_en, // one-cycle array write strobe
  output logic wr_mask, // byte mask for wr_data
  output logic rd_en, // one-cycle array read strobe
  output logic clk_stop, // active clock-stop state
  output logic sleeping, // hybrid sleep state
  output logic powered_down, // deep power-down state
  output logic array_invalid // array lost after power-down
);
  typedef enum {ST_IDLE, ST_CA, ST_LAT, ST_RD, ST_WR, ST_WAIT_HI,
    ST_SLEEP, ST_SLEEP_OUT, ST_PD, ST_PD_OUT} st_e;
  st_e st_reg, st_next;
  // pin synchronisers: first stage read only by second stage
  logic [3:0] s1_reg, s2_reg;
  logic [7:0] dq1_reg, dq2_reg;
  logic ck_old_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // idle pin levels: reset high, select high, clock low, strobe low
      s1_reg <= 4'hC;
      s2_reg <= 4'hC;
      dq1_reg <= 8'h00;
      dq2_reg <= 8'h00;
      ck_old_reg <= 1'b0;
    end else begin
      s1_reg <= {bus.reset_n, bus.sel_n, bus.ck, bus.rws_h};
      s2_reg <= s1_reg;
      dq1_reg <= bus.dq_h;
      dq2_reg <= dq1_reg;
      ck_old_reg <= s2_reg[1];
    end
  end
  wire hw_rst_n = s2_reg[3];
  wire sel_n = s2_reg[2];
  wire ck_s = s2_reg[1];
  wire mask_s = s2_reg[0];
  wire ck_edge = ck_s ^ ck_old_reg;
  // command-address and control state
  logic [2:0] ca_cnt_reg;
  logic [7:0] cmd_reg, sel_byte_reg;
  logic extra_lat_reg;
  logic [4:0] lat_cnt_reg;
  logic [7:0] cr0_reg, cr1_reg;
  logic sel_n_old_reg;
  logic [15:0] stop_cnt_reg;
  wire is_read = (cmd_reg & CMD_READ_BIT) != 8'h00;
  wire is_reg = (cmd_reg & CMD_REG_BIT) != 8'h00;
  wire sel_fall = sel_n_old_reg && !sel_n;
  wire sel_rise = !sel_n_old_reg && sel_n;
  wire ca_last = ck_edge && (ca_cnt_reg == 3'(CA_BYTES - 1));
  wire [4:0] lat_total = extra_lat_reg ? 5'(2 * LAT_CYC) : 5'(LAT_CYC);
  wire lat_done = ck_edge && (lat_cnt_reg == lat_total - 5'd1);
  wire stop_hit = stop_cnt_reg == 16'(STOP_CYC);
  // one shared delay timer for power state transitions
  logic t_start, t_done, t_busy;
  logic [19:0] t_count;
  ps_wait #(.W(20)) u_wait (
    .clk(clk),
    .rstn(rstn),
    .start(t_start),
    .count(t_count),
    .busy(t_busy),
    .done(t_done)
  );
  logic pd_arm_reg, hs_arm_reg;
  // entry delays start when the arming write completes, at select rise
  wire entry_go = st_reg == ST_WR && sel_n && (hs_arm_reg || pd_arm_reg);
  // next state
  always_comb begin
    st_next = st_reg;
    t_start = 1'b0;
    t_count = 20'd1;
    case (st_reg)
      ST_IDLE: begin
        if (!sel_n) st_next = ST_CA;
        else if (t_done && hs_arm_reg) st_next = ST_SLEEP;
        else if (t_done && pd_arm_reg) st_next = ST_PD;
      end
      ST_CA: if (ca_last) st_next = (is_reg && !is_read) ? ST_WR : ST_LAT;
      ST_LAT: if (lat_done) st_next = is_read ? ST_RD : ST_WR;
      ST_RD, ST_WR: if (entry_go) begin
        t_start = 1'b1;
        t_count = hs_arm_reg ? 20'(SLEEP_IN_CYC) : 20'(PD_IN_CYC);
      end
      ST_SLEEP: if (sel_fall) begin
        st_next = ST_SLEEP_OUT;
        t_start = 1'b1;
        t_count = 20'(SLEEP_OUT_CYC);
      end
      ST_SLEEP_OUT: if (t_done) st_next = ST_WAIT_HI;
      ST_PD: if (sel_rise) begin
        st_next = ST_PD_OUT;
        t_start = 1'b1;
        t_count = 20'(PD_OUT_CYC);
      end
      ST_PD_OUT: if (t_done) st_next = ST_IDLE;
      ST_WAIT_HI: if (sel_n) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
    // select high aborts any transfer back to standby
    if ((st_reg == ST_CA || st_reg == ST_LAT || st_reg == ST_RD ||
         st_reg == ST_WR) && sel_n) st_next = ST_IDLE;
    if (!hw_rst_n) st_next = ST_IDLE;
  end
  // decoded write of a register word on each data clock edge of zero-latency write
  wire reg_wr = st_reg == ST_WR && is_reg && ck_edge;
  wire arm_hs = reg_wr && sel_byte_reg == REG_SEL_CR1 && dq2_reg[SLEEP_POS];
  wire arm_pd = reg_wr && sel_byte_reg == REG_SEL_CR0
                && !dq2_reg[PD_CTRL_POS];
  // state and control registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_IDLE;
      sel_n_old_reg <= 1'b1;
      ca_cnt_reg <= 3'd0;
      cmd_reg <= 8'h00;
      sel_byte_reg <= 8'h00;
      extra_lat_reg <= 1'b0;
      lat_cnt_reg <= 5'd0;
      cr0_reg <= CR0_RESET;
      cr1_reg <= CR1_RESET;
      hs_arm_reg <= 1'b0;
      pd_arm_reg <= 1'b0;
      stop_cnt_reg <= 16'd0;
    end else begin
      st_reg <= st_next;
      sel_n_old_reg <= sel_n;
      if (st_reg == ST_IDLE && !sel_n) begin
        ca_cnt_reg <= 3'd0;
        extra_lat_reg <= refresh_busy;
      end else if (st_reg == ST_CA && ck_edge) begin
        ca_cnt_reg <= ca_cnt_reg + 3'd1;
        if (ca_cnt_reg == 3'd0) cmd_reg <= dq2_reg;
        if (ca_cnt_reg == 3'(CA_BYTES - 1)) sel_byte_reg <= dq2_reg;
      end
      lat_cnt_reg <= (st_reg == ST_LAT && ck_edge) ? lat_cnt_reg + 5'd1
                   : (st_reg == ST_LAT) ? lat_cnt_reg : 5'd0;
      // stall counter for clock-stop, counts only in data phase
      if ((st_reg == ST_RD || st_reg == ST_WR) && !ck_edge) begin
        if (!stop_hit) stop_cnt_reg <= stop_cnt_reg + 16'd1;
      end else stop_cnt_reg <= 16'd0;
      if (arm_hs) cr1_reg[SLEEP_POS] <= 1'b1;
      if (arm_pd) cr0_reg[PD_CTRL_POS] <= 1'b0;
      // sleep keeps registers; select fall clears bit only
      if (st_reg == ST_SLEEP && sel_fall) cr1_reg[SLEEP_POS] <= 1'b0;
      hs_arm_reg <= (hs_arm_reg || arm_hs) && st_next != ST_SLEEP;
      pd_arm_reg <= (pd_arm_reg || arm_pd) && st_next != ST_PD;
      // power-down exit and pin reset give post-power-on registers
      if (st_reg == ST_PD_OUT || !hw_rst_n) begin
        cr0_reg <= CR0_RESET;
        cr1_reg <= CR1_RESET;
        hs_arm_reg <= 1'b0;
        pd_arm_reg <= 1'b0;
      end
    end
  end
  // pin drivers and user-side outputs, all registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus.dq_d <= 8'h00;
      bus.dq_d_oe <= 1'b0;
      bus.rws_d <= 1'b0;
      bus.rws_d_oe <= 1'b0;
      wr_data <= 8'h00;
      wr_en <= 1'b0;
      wr_mask <= 1'b0;
      rd_en <= 1'b0;
      clk_stop <= 1'b0;
      sleeping <= 1'b0;
      powered_down <= 1'b0;
      array_invalid <= 1'b0;
    end else begin
      bus.dq_d_oe <= st_next == ST_RD;
      bus.rws_d_oe <= st_next == ST_CA || st_next == ST_RD
                      || (st_next == ST_LAT && is_read);
      if (st_next == ST_CA) bus.rws_d <= refresh_busy;
      else if (st_next == ST_LAT) bus.rws_d <= 1'b0;
      else if (st_reg == ST_RD && ck_edge) bus.rws_d <= ck_s;
      // zero-latency write: strobe released after command-address
      // the host keeps off the strobe in this write
      if (st_reg == ST_RD && ck_edge) bus.dq_d <= rd_data;
      rd_en <= st_reg == ST_RD && ck_edge;
      wr_en <= st_reg == ST_WR && ck_edge && !is_reg;
      wr_data <= dq2_reg;
      // zero-latency write never masks; otherwise strobe masks
      wr_mask <= is_reg ? 1'b0 : mask_s;
      clk_stop <= (st_reg == ST_RD || st_reg == ST_WR) && stop_hit
                  && !ck_edge;
      sleeping <= st_next == ST_SLEEP || st_next == ST_SLEEP_OUT;
      powered_down <= st_next == ST_PD || st_next == ST_PD_OUT;
      if (st_reg == ST_PD) array_invalid <= 1'b1;
      else if (wr_en) array_invalid <= 1'b0;
    end
  end
  // timer busy flag not needed: the done pulse steers the states
  wire unused_ok = t_busy;
endmodule : ps_device

// ===== ps_properties.sv
`timescale 1ns/100ps
// watches the link between host and device, one clock domain
module ps_properties #(
  parameter int STOP_CYC = 4, // clock-stop detect cycles
  parameter int SLEEP_OUT_CYC = 4, // sleep exit delay
  parameter int PD_OUT_CYC = 4 // power-down exit delay
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, low
  input wire logic sel_n, // select, low active
  input wire logic ck, // true clock
  input wire logic reset_n, // hardware reset pin
  input wire logic dq_h_oe, // host drives data
  input wire logic [7:0] dq_d, // device data out
  input wire logic dq_d_oe, // device drives data
  input wire logic rws_d, // device strobe out
  input wire logic rws_d_oe, // device drives strobe
  input wire logic refresh_busy, // refresh still running
  input wire logic clk_stop, // clock-stop state
  input wire logic sleeping, // hybrid sleep
  input wire logic powered_down // deep power-down
);
  localparam int SW = SLEEP_OUT_CYC + 8; // sleep wake bound
  localparam int PW = PD_OUT_CYC + 8; // power-down exit bound
  logic ck_reg; // last sampled clock level
  logic [15:0] still_reg; // cycles since clock last moved
  wire moved = ck != ck_reg; // clock edge seen
  // saturates so a long idle never wraps to a small count
  wire [15:0] still_next = moved ? 16'h0000 :
    (&still_reg) ? still_reg : still_reg + 16'h0001;
  // stall counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ck_reg <= 1'b0;
      still_reg <= 16'h0000;
    end else begin
      ck_reg <= ck;
      still_reg <= still_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // allows for the two-flop input sampling lag
  property p_standby; sel_n [*5] |-> !dq_d_oe && !rws_d_oe; endproperty
  property p_hw_reset; !reset_n [*5] |-> !dq_d_oe && !rws_d_oe; endproperty
  property p_no_clash; !(dq_d_oe && dq_h_oe); endproperty
  sequence s_start;
    $fell(sel_n) && reset_n && !sleeping && !powered_down;
  endsequence
  property p_ca_strobe; s_start |-> ##[1:8] rws_d_oe; endproperty
  property p_refresh;
    s_start ##0 refresh_busy |-> ##[1:8] (rws_d_oe && rws_d);
  endproperty
  property p_stop_late; $rose(clk_stop) |-> still_reg >= 16'(STOP_CYC);
  endproperty
  property p_resume; clk_stop && moved |-> ##[1:4] !clk_stop; endproperty
  property p_stop_hold;
    clk_stop && $past(clk_stop) && $past(dq_d_oe) |-> dq_d_oe && $stable(dq_d);
  endproperty
  property p_low_quiet;
    sleeping || powered_down |-> !dq_d_oe && !rws_d_oe;
  endproperty
  property p_wake; sleeping && $fell(sel_n) |-> ##[1:SW] !sleeping;
  endproperty
  property p_pd_exit; powered_down && $rose(sel_n) |-> ##[1:PW] !powered_down;
  endproperty
  a_standby: assert property (p_standby) else $error("drives in standby");
  a_hw_reset: assert property (p_hw_reset) else $error("drives in reset");
  a_no_clash: assert property (p_no_clash) else $error("data clash");
  a_ca_strobe: assert property (p_ca_strobe) else $error("no strobe");
  a_refresh: assert property (p_refresh) else $error("no extra wait");
  a_stop_late: assert property (p_stop_late) else $error("early stop");
  a_resume: assert property (p_resume) else $error("stuck stop");
  a_stop_hold: assert property (p_stop_hold) else $error("lost data");
  a_low_quiet: assert property (p_low_quiet) else $error("drives asleep");
  a_wake: assert property (p_wake) else $error("no wake");
  a_pd_exit: assert property (p_pd_exit) else $error("no exit");
  c_stop: cover property ($rose(clk_stop));
  c_sleep: cover property ($rose(sleeping));
  c_pd: cover property ($rose(powered_down));
  c_refresh: cover property ($fell(sel_n) && refresh_busy);
endmodule : ps_properties

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ps_pkg::*;
  typedef struct packed {op_e op; logic [7:0] d; logic rf;} row_s;
  logic clk; // 200 MHz system clock
  logic rstn; // power-on reset, low
  logic refresh_busy; // refresh model
  logic [7:0] rd_data; // array read value
  logic [7:0] wr_data; // array write value
  logic wr_en, wr_mask, clk_stop; // transfer status
  logic sleeping, powered_down, array_invalid; // power states
  int error_cnt, comparisons; // tallies
  row_s rows [0:5] = '{'{OP_READ, 8'hA5, 1'b0}, '{OP_READ, 8'h5A, 1'b1},
    '{OP_WRITE, 8'hC3, 1'b0}, '{OP_WRITE, 8'h3C, 1'b1},
    '{OP_REG_WRITE, 8'h00, 1'b0}, '{OP_REG_WRITE, 8'h00, 1'b1}};
  ps_link lk();
  // entry delays and clock-stop limit keep their real values
  ps_device #(.SLEEP_OUT_CYC(40), .PD_OUT_CYC(50)) ps_device_i (.clk(clk),
    .rstn(rstn),
    .bus(lk.dev), .refresh_busy(refresh_busy), .rd_data(rd_data),
    .wr_data(wr_data), .wr_en(wr_en), .wr_mask(wr_mask), .rd_en(),
    .clk_stop(clk_stop), .sleeping(sleeping), .powered_down(powered_down),
    .array_invalid(array_invalid));
  ps_properties #(.STOP_CYC(CLK_STOP_CYC), .SLEEP_OUT_CYC(40),
    .PD_OUT_CYC(50))
    ps_properties_i (.clk(clk), .rstn(rstn), .sel_n(lk.sel_n), .ck(lk.ck),
    .reset_n(lk.reset_n), .dq_h_oe(lk.dq_h_oe), .dq_d(lk.dq_d),
    .dq_d_oe(lk.dq_d_oe), .rws_d(lk.rws_d), .rws_d_oe(lk.rws_d_oe),
    .refresh_busy(refresh_busy), .clk_stop(clk_stop), .sleeping(sleeping),
    .powered_down(powered_down));
  // clock source
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // inputs move 1 ns after the edge, never on it
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  // bounded wait on a power flag; a miss ends the run
  task automatic waitv(input bit pd, input logic v);
    for (int n = 0; n < 3000 && (pd ? powered_down : sleeping) !== v; n++)
      step();
    chk(pd ? "pd" : "sleep", 8'(pd ? powered_down : sleeping), 8'(v));
    if (error_cnt != 0) test_done();
  endtask : waitv
  task automatic sel_pulse();
    lk.sel_n = 1'b0;
    step();
    lk.sel_n = 1'b1;
  endtask : sel_pulse
  // one host transfer; data beats follow the command-address bytes
  task automatic xfer(input row_s r, input logic [7:0] rsel, input bit stall);
    logic stb;
    logic wm;
    logic [7:0] got;
    logic [7:0] wd;
    logic [7:0] cmd;
    stb = 1'b0;
    wm = 1'b0;
    got = ~r.d;
    wd = ~r.d;
    cmd = (r.op == OP_READ) ? CMD_READ_BIT :
      (r.op == OP_REG_WRITE) ? CMD_REG_BIT : 8'h00;
    rd_data = r.d;
    refresh_busy = r.rf;
    lk.sel_n = 1'b0;
    // host mask held high but never driven: zero-latency write ignores it
    lk.rws_h = (r.op == OP_REG_WRITE);
    // select leads the first clock edge by one cycle
    step();
    for (int i = 0; i < CA_BYTES + 60; i++) begin
      // write data waits out the longest latency, so no bus overlap
      lk.dq_h_oe = i < CA_BYTES || r.op == OP_REG_WRITE ||
        (r.op == OP_WRITE && i >= CA_BYTES + 4 * LAT_CYC);
      // register target rides in the last command-address byte
      lk.dq_h = i == 0 ? cmd :
        (r.op == OP_REG_WRITE && i == CA_BYTES - 1) ? rsel :
        i < CA_BYTES ? 8'h00 : r.d;
      // even toggle count so far: clock parks low
      if (stall && i == CA_BYTES + 40) begin
        repeat (26) step();
        chk("stop", 8'(clk_stop), 8'h01);
        chk("held", lk.dq_d, r.d);
      end
      if (stall && i == CA_BYTES + 46)
        chk("resume", 8'(clk_stop), 8'h00);
      lk.ck = ~lk.ck;
      lk.clock_complement = ~lk.ck;
      step();
      if (i < CA_BYTES + 4 && lk.rws_d_oe === 1'b1 && lk.rws_d === 1'b1)
        stb = 1'b1;
      if (i >= CA_BYTES && lk.dq_d_oe === 1'b1) got = lk.dq_d;
      if (wr_en === 1'b1) begin
        wd = wr_data;
        wm = wm | wr_mask;
      end
    end
    // transfer stays far below the select-low limit
    lk.sel_n = 1'b1;
    lk.dq_h_oe = 1'b0;
    refresh_busy = 1'b0;
    repeat (8) step();
    chk("ca_strobe", 8'(stb), 8'(r.rf));
    if (r.op == OP_READ) chk("rd", got, r.d);
    if (r.op == OP_WRITE) chk("wr", wd, r.d);
    chk("mask", 8'(wm), 8'h00);
  endtask : xfer
  // main sequence
  initial begin
    {rstn, refresh_busy, rd_data} = '0;
    {lk.sel_n, lk.reset_n, lk.ck, lk.clock_complement} = 4'b1101;
    {lk.dq_h, lk.dq_h_oe, lk.rws_h, lk.rws_h_oe} = '0;
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    lk.reset_n = 1'b1;
    repeat (6) step();
    chk("idle_oe", {6'h00, lk.dq_d_oe, lk.rws_d_oe}, 8'h00);
    $display("reset test done");
    foreach (rows[k]) begin
      xfer(rows[k], REG_SEL_CR1, 1'b0);
      $display("row %0d done", k);
    end
    xfer('{OP_READ, 8'h96, 1'b0}, REG_SEL_CR1, 1'b1);
    $display("clock stop test done");
    xfer('{OP_REG_WRITE, 8'h20, 1'b0}, REG_SEL_CR1, 1'b0);
    waitv(1'b0, 1'b1);
    sel_pulse();
    waitv(1'b0, 1'b0);
    xfer('{OP_READ, 8'h69, 1'b0}, REG_SEL_CR1, 1'b0);
    xfer('{OP_REG_WRITE, 8'h20, 1'b0}, REG_SEL_CR1, 1'b0);
    waitv(1'b0, 1'b1);
    lk.reset_n = 1'b0;
    repeat (8) step();
    lk.reset_n = 1'b1;
    waitv(1'b0, 1'b0);
    $display("sleep test done");
    xfer('{OP_REG_WRITE, 8'h00, 1'b0}, REG_SEL_CR0, 1'b0);
    waitv(1'b1, 1'b1);
    sel_pulse();
    waitv(1'b1, 1'b0);
    chk("invalid", 8'(array_invalid), 8'h01);
    xfer('{OP_WRITE, 8'h5A, 1'b0}, REG_SEL_CR1, 1'b0);
    chk("valid", 8'(array_invalid), 8'h00);
    $display("power-down test done");
    test_done();
  end
endmodule : tb_top
